// *** logic/pdpc_defs.vh ***
// Constants for the port direction and pull-up control block
`ifndef PDPC_DEFS_VH
`define PDPC_DEFS_VH

// Direction register addresses
`define PDPC_ADDR_DIR0   16'hFF20
`define PDPC_ADDR_DIR2   16'hFF22
`define PDPC_ADDR_DIR3   16'hFF23
`define PDPC_ADDR_DIR4   16'hFF24
`define PDPC_ADDR_DIR5   16'hFF25
`define PDPC_ADDR_DIR6   16'hFF26
`define PDPC_ADDR_DIR7   16'hFF27
`define PDPC_ADDR_DIR8   16'hFF28
`define PDPC_ADDR_DIR9   16'hFF29
`define PDPC_ADDR_DIR12  16'hFF2C
// Pull-up select register addresses
`define PDPC_ADDR_PU0    16'hFF30
`define PDPC_ADDR_PU2    16'hFF32
`define PDPC_ADDR_PU3    16'hFF33
`define PDPC_ADDR_PU4    16'hFF34
`define PDPC_ADDR_PU5    16'hFF35
`define PDPC_ADDR_PU6    16'hFF36
`define PDPC_ADDR_PU7    16'hFF37
`define PDPC_ADDR_RESISTOR_SELECT_PORT12   16'hFF3C

// Reset values
`define PDPC_DIR_RST     8'hFF
`define PDPC_PU_RST      8'h00
`define PDPC_RD_NONE     8'h00

// Implemented pin masks, per port
`define PDPC_MASK_P0     8'h3F
`define PDPC_MASK_P2     8'h3F
`define PDPC_MASK_P3     8'h1F
`define PDPC_MASK_FULL   8'hFF
`define PDPC_MASK_P6PU   8'hF0
`define PDPC_MASK_P7     8'h0F
`define PDPC_MASK_P12    8'h01

`endif

// *** logic/pdpc_reg8.v ***
// One 8-bit control register with masked writes and fixed unused bits
`timescale 1ns/1ps
module pdpc_reg8 #(
  parameter [7:0] RST_VAL  = 8'hFF,   // Value after reset
  parameter [7:0] MASK     = 8'hFF,   // Positions with a pin behind them
  parameter       BIT_OK   = 1        // Single-bit writes accepted
) (
  input  wire       clock_i,          // System clock
  input  wire       rst_i,            // Synchronous reset, active high
  input  wire       sel_i,            // Register addressed this cycle
  input  wire       wr_i,             // Write strobe
  input  wire       bit_i,            // Access is single-bit
  input  wire [2:0] bit_sel_i,        // Bit number for single-bit access
  input  wire [7:0] wdata_i,          // Write data
  output reg  [7:0] q_o               // Register contents
);

  reg [7:0] q_nxt;
  reg [7:0] wmask;

  // =======================================================
  // Write merge
  always @* begin
    wmask = bit_i ? (8'h01 << bit_sel_i) : 8'hFF;
    q_nxt = q_o;
    if (sel_i && wr_i && (!bit_i || BIT_OK != 0)) begin
      q_nxt = (q_o & ~wmask) | (wdata_i & wmask);
    end
    // Unused positions hold their reset value
    q_nxt = (q_nxt & MASK) | (RST_VAL & ~MASK);
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      q_o <= RST_VAL;
    end else begin
      q_o <= q_nxt;
    end
  end

endmodule // pdpc_reg8

// *** logic/pdpc_port_ctrl.v ***
// Port direction and pull-up control registers
// Behaviour
// - One direction bit controls one pin
// - Ports 0,2-7,12 direction: bit or byte writes
// - Ports 8,9 direction: byte writes only
// - Direction registers reset to all ones
// - Port 1 input only, no control
// - Port 0 output change raises interrupt request
// - One pull-up bit per pin of ports 0,2-7,12 (none for ports 8,9); port 6 has bits for its upper four pins only
// - Pull-up registers take bit or byte writes
// - Pull-up registers reset to zero
// - Pull-up connects regardless of direction
`timescale 1ns/1ps
`include "pdpc_defs.vh"
module pdpc_port_ctrl (
  input  wire        clock_i,          // System clock, 125 MHz
  input  wire        rst_i,            // Synchronous reset, active high
  input  wire [15:0] addr_i,           // Register address
  input  wire        wr_i,             // Write strobe
  input  wire        rd_i,             // Read strobe
  input  wire        bit_i,            // Single-bit access when high
  input  wire [2:0]  bit_sel_i,        // Bit number for single-bit access
  input  wire [7:0]  wdata_i,          // Write data
  input  wire [5:0]  port0_level_i,    // Port 0 driven output levels
  output reg  [7:0]  rdata_o,          // Read data, valid cycle after rd_i
  output reg  [5:0]  dir0_o,           // Port 0 direction
  output reg  [5:0]  dir2_o,           // Port 2 direction
  output reg  [4:0]  dir3_o,           // Port 3 direction
  output reg  [7:0]  dir4_o,           // Port 4 direction
  output reg  [7:0]  dir5_o,           // Port 5 direction
  output reg  [7:0]  dir6_o,           // Port 6 direction
  output reg  [3:0]  dir7_o,           // Port 7 direction
  output reg  [7:0]  dir8_o,           // Port 8 direction
  output reg  [7:0]  dir9_o,           // Port 9 direction
  output reg         dir12_o,          // Port 12 direction
  output reg  [5:0]  pu0_o,            // Port 0 pull-up enable
  output reg  [5:0]  pu2_o,            // Port 2 pull-up enable
  output reg  [4:0]  pu3_o,            // Port 3 pull-up enable
  output reg  [7:0]  pu4_o,            // Port 4 pull-up enable
  output reg  [7:0]  pu5_o,            // Port 5 pull-up enable
  output reg  [3:0]  pu6_o,            // Port 6 upper pull-up enable
  output reg  [3:0]  pu7_o,            // Port 7 pull-up enable
  output reg         resistor_select_port12_o,           // Port 12 pull-up enable
  output reg  [5:0]  ext_irq_set_o     // Port 0 interrupt request pulses
);

  wire [7:0] d0, d2, d3, d4, d5, d6, d7, d8, d9, d12;
  wire [7:0] u0, u2, u3, u4, u5, u6, u7, u12;
  reg  [7:0] rdata_nxt;
  reg  [5:0] lvl0_s1_r;
  reg  [5:0] lvl0_s2_r;
  reg  [5:0] lvl0_prev_r;
  wire [7:0] dir_rst_w = `PDPC_DIR_RST;
  wire [7:0] pu_rst_w  = `PDPC_PU_RST;

  // =======================================================
  // Register bank
  // Every register sees the shared bus; only the decoded one takes a write.
  // Single-bit writes to ports 8 and 9 are dropped inside the register.
  // Unused positions are forced back to the reset value on every edge.
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_P0), .BIT_OK(1)) u_dir0 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR0), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d0));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_P2), .BIT_OK(1)) u_dir2 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR2), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d2));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_P3), .BIT_OK(1)) u_dir3 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR3), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d3));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(1)) u_dir4 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR4), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d4));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(1)) u_dir5 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR5), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d5));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(1)) u_dir6 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR6), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d6));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_P7), .BIT_OK(1)) u_dir7 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR7), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d7));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(0)) u_dir8 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR8), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d8));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(0)) u_dir9 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR9), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d9));
  pdpc_reg8 #(.RST_VAL(`PDPC_DIR_RST), .MASK(`PDPC_MASK_P12), .BIT_OK(1)) u_dir12 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_DIR12), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(d12));

  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_P0), .BIT_OK(1)) u_pu0 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU0), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u0));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_P2), .BIT_OK(1)) u_pu2 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU2), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u2));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_P3), .BIT_OK(1)) u_pu3 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU3), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u3));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(1)) u_pu4 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU4), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u4));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_FULL), .BIT_OK(1)) u_pu5 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU5), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u5));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_P6PU), .BIT_OK(1)) u_pu6 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU6), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u6));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_P7), .BIT_OK(1)) u_pu7 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_PU7), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u7));
  pdpc_reg8 #(.RST_VAL(`PDPC_PU_RST), .MASK(`PDPC_MASK_P12), .BIT_OK(1)) u_resistor_select_port12 (
    .clock_i(clock_i), .rst_i(rst_i), .sel_i(addr_i == `PDPC_ADDR_RESISTOR_SELECT_PORT12), .wr_i(wr_i),
    .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .q_o(u12));

  // =======================================================
  // Read mux; ports 8 and 9 are write-only, port 1 has nothing
  always @* begin
    rdata_nxt = `PDPC_RD_NONE;
    if (addr_i == `PDPC_ADDR_DIR0) begin
      rdata_nxt = d0;
    end else if (addr_i == `PDPC_ADDR_DIR2) begin
      rdata_nxt = d2;
    end else if (addr_i == `PDPC_ADDR_DIR3) begin
      rdata_nxt = d3;
    end else if (addr_i == `PDPC_ADDR_DIR4) begin
      rdata_nxt = d4;
    end else if (addr_i == `PDPC_ADDR_DIR5) begin
      rdata_nxt = d5;
    end else if (addr_i == `PDPC_ADDR_DIR6) begin
      rdata_nxt = d6;
    end else if (addr_i == `PDPC_ADDR_DIR7) begin
      rdata_nxt = d7;
    end else if (addr_i == `PDPC_ADDR_DIR12) begin
      rdata_nxt = d12;
    end else if (addr_i == `PDPC_ADDR_PU0) begin
      rdata_nxt = u0;
    end else if (addr_i == `PDPC_ADDR_PU2) begin
      rdata_nxt = u2;
    end else if (addr_i == `PDPC_ADDR_PU3) begin
      rdata_nxt = u3;
    end else if (addr_i == `PDPC_ADDR_PU4) begin
      rdata_nxt = u4;
    end else if (addr_i == `PDPC_ADDR_PU5) begin
      rdata_nxt = u5;
    end else if (addr_i == `PDPC_ADDR_PU6) begin
      rdata_nxt = u6;
    end else if (addr_i == `PDPC_ADDR_PU7) begin
      rdata_nxt = u7;
    end else if (addr_i == `PDPC_ADDR_RESISTOR_SELECT_PORT12) begin
      rdata_nxt = u12;
    end
  end

  // =======================================================
  // Output registers and port 0 interrupt source
  always @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o       <= `PDPC_RD_NONE;
      dir0_o        <= dir_rst_w[5:0];
      dir2_o        <= dir_rst_w[5:0];
      dir3_o        <= dir_rst_w[4:0];
      dir4_o        <= dir_rst_w;
      dir5_o        <= dir_rst_w;
      dir6_o        <= dir_rst_w;
      dir7_o        <= dir_rst_w[3:0];
      dir8_o        <= dir_rst_w;
      dir9_o        <= dir_rst_w;
      dir12_o       <= dir_rst_w[0];
      pu0_o         <= pu_rst_w[5:0];
      pu2_o         <= pu_rst_w[5:0];
      pu3_o         <= pu_rst_w[4:0];
      pu4_o         <= pu_rst_w;
      pu5_o         <= pu_rst_w;
      pu6_o         <= pu_rst_w[7:4];
      pu7_o         <= pu_rst_w[3:0];
      resistor_select_port12_o        <= pu_rst_w[0];
      lvl0_s1_r     <= 6'h00;
      lvl0_s2_r     <= 6'h00;
      lvl0_prev_r   <= 6'h00;
      ext_irq_set_o <= 6'h00;
    end else begin
      if (rd_i) begin
        rdata_o <= rdata_nxt;
      end
      dir0_o      <= d0[5:0];
      dir2_o      <= d2[5:0];
      dir3_o      <= d3[4:0];
      dir4_o      <= d4;
      dir5_o      <= d5;
      dir6_o      <= d6;
      dir7_o      <= d7[3:0];
      dir8_o      <= d8;
      dir9_o      <= d9;
      dir12_o     <= d12[0];
      pu0_o       <= u0[5:0];
      pu2_o       <= u2[5:0];
      pu3_o       <= u3[4:0];
      pu4_o       <= u4;
      pu5_o       <= u5;
      pu6_o       <= u6[7:4];
      pu7_o       <= u7[3:0];
      resistor_select_port12_o      <= u12[0];
      // Pin levels pass two flops before the edge compare.
      // The compare uses the internal register, which leads dir0_o
      // by one cycle, so the mask matches the visible direction
      // at the cycle the pulse appears.
      lvl0_s1_r   <= port0_level_i;
      lvl0_s2_r   <= lvl0_s1_r;
      lvl0_prev_r <= lvl0_s2_r;
      // Level change on an output-mode pin raises request
      ext_irq_set_o <= (lvl0_s2_r ^ lvl0_prev_r) & ~d0[5:0];
    end
  end

endmodule // pdpc_port_ctrl

// *** tb/pdpc_port_ctrl_props.sv ***
// Assertions on the port control block ports
`timescale 1ns/1ps
module pdpc_port_ctrl_props (
  input wire        clock_i,       // Clock
  input wire        rst_i,         // Reset
  input wire [15:0] addr_i,        // Address
  input wire        wr_i,          // Write
  input wire        rd_i,          // Read
  input wire        bit_i,         // Bit access
  input wire [2:0]  bit_sel_i,     // Bit number
  input wire [7:0]  wdata_i,       // Write data
  input wire [5:0]  port0_level_i, // Pin levels
  input wire [7:0]  rdata_o,       // Read data
  input wire [5:0]  dir0_o,        // Port 0 direction
  input wire [7:0]  dir4_o,        // Port 4 direction
  input wire [7:0]  dir8_o,        // Port 8 direction
  input wire [7:0]  pu4_o,         // Port 4 pull-up
  input wire [5:0]  ext_irq_set_o  // Request pulses
);
  // ==========
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_RST_VAL: assert property ($fell(rst_i) |-> dir4_o == 8'hFF && dir8_o == 8'hFF && pu4_o == 8'h00)
    else $error("reset values wrong");
  AST_BYTE_WR: assert property (wr_i && !bit_i && addr_i == 16'hFF24 |-> ##2 dir4_o == $past(wdata_i, 2))
    else $error("byte write lost");
  AST_BIT_WR: assert property (wr_i && bit_i && addr_i == 16'hFF20 && bit_sel_i < 3'h6 |->
    ##2 dir0_o[$past(bit_sel_i, 2)] == $past(wdata_i[bit_sel_i], 2)) else $error("bit write lost");
  AST_WO_BIT: assert property (wr_i && bit_i && addr_i == 16'hFF28 ##1 1'b1 |=> $stable(dir8_o))
    else $error("bit write taken");
  AST_PU_BIT: assert property (wr_i && bit_i && addr_i == 16'hFF34 |->
    ##2 pu4_o[$past(bit_sel_i, 2)] == $past(wdata_i[bit_sel_i], 2)) else $error("pull-up bit lost");
  AST_FIXED: assert property (rd_i && addr_i == 16'hFF20 |=> rdata_o[7:6] == 2'h3)
    else $error("unused bits not one");
  AST_NONE: assert property (rd_i && (addr_i == 16'hFF21 || addr_i == 16'hFF28) |=> rdata_o == 8'h00)
    else $error("empty read not zero");
  AST_IRQ_OUT: assert property ($changed(port0_level_i[0]) && !dir0_o[0] ##1 !dir0_o[0] [*3] |-> ext_irq_set_o[0])
    else $error("missing request");
  AST_IRQ_IN: assert property ($changed(port0_level_i[0]) && dir0_o[0] ##1 dir0_o[0] [*3] |-> !ext_irq_set_o[0])
    else $error("request from input pin");
  AST_IRQ_WHY: assert property (ext_irq_set_o[0] |-> $past(port0_level_i[0], 3) != $past(port0_level_i[0], 4))
    else $error("request without change");
endmodule // pdpc_port_ctrl_props
bind pdpc_port_ctrl pdpc_port_ctrl_props pdpc_port_ctrl_props_inst (.clock_i(clock_i), .rst_i(rst_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i),
  .port0_level_i(port0_level_i), .rdata_o(rdata_o), .dir0_o(dir0_o), .dir4_o(dir4_o), .dir8_o(dir8_o),
  .pu4_o(pu4_o), .ext_irq_set_o(ext_irq_set_o));

// *** tb/pdpc_pin_model.sv ***
// Model of the port 0 pins and what drives them
`timescale 1ns/1ps
module pdpc_pin_model (
  input  wire        clock_i, // Clock
  input  wire        en_i,    // Toggle pins
  output reg  [5:0]  level_o, // Pin levels
  output reg  [15:0] count_o  // Toggles made
);
  reg [2:0] div_r;
  initial begin
    level_o = 6'h00;
    count_o = 16'h0000;
    div_r = 3'h0;
  end
  // Off the sampling edge, one change per 8 cycles
  always @(negedge clock_i) begin
    if (en_i) begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h7) begin
        level_o <= ~level_o;
        count_o <= count_o + 16'h0001;
      end
    end
  end
endmodule // pdpc_pin_model

// *** tb/pdpc_port_ctrl_bench.sv ***
// Self-checking bench for the port control block
`timescale 1ns/1ps
module pdpc_port_ctrl_bench;
  reg         clock_i, rst_i, wr_i, rd_i, bit_i, en;
  reg  [15:0] addr_i, t0;
  reg  [2:0]  bit_sel_i;
  reg  [7:0]  wdata_i, m [0:31];
  reg  [31:0] r;
  wire [7:0]  rdata_o, dir4_o, dir5_o, dir6_o, dir8_o, dir9_o, pu4_o, pu5_o;
  wire [5:0]  dir0_o, dir2_o, pu0_o, pu2_o, ext_irq_set_o, lvl;
  wire [4:0]  dir3_o, pu3_o;
  wire [3:0]  dir7_o, pu6_o, pu7_o;
  wire        dir12_o, resistor_select_port12_o;
  wire [15:0] tog;
  integer     mismatches, check_count, j, pulses, others;
  pdpc_port_ctrl pdpc_port_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .bit_i(bit_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i), .port0_level_i(lvl),
    .rdata_o(rdata_o), .dir0_o(dir0_o), .dir2_o(dir2_o), .dir3_o(dir3_o), .dir4_o(dir4_o), .dir5_o(dir5_o),
    .dir6_o(dir6_o), .dir7_o(dir7_o), .dir8_o(dir8_o), .dir9_o(dir9_o), .dir12_o(dir12_o), .pu0_o(pu0_o),
    .pu2_o(pu2_o), .pu3_o(pu3_o), .pu4_o(pu4_o), .pu5_o(pu5_o), .pu6_o(pu6_o), .pu7_o(pu7_o),
    .resistor_select_port12_o(resistor_select_port12_o), .ext_irq_set_o(ext_irq_set_o));
  pdpc_pin_model pdpc_pin_model_inst (.clock_i(clock_i), .en_i(en), .level_o(lvl), .count_o(tog));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    if (!rst_i) begin
      pulses <= pulses + ext_irq_set_o[0];
      others <= others + (|ext_irq_set_o[5:1]);
    end
  end
  // ==========
  // Model and tasks
  function [7:0] mk(input [4:0] a);
    case (a)
      0, 2, 16, 18: mk = 8'h3F;
      3, 19: mk = 8'h1F;
      4, 5, 6, 8, 9, 20, 21: mk = 8'hFF;
      7, 23: mk = 8'h0F;
      12, 28: mk = 8'h01;
      22: mk = 8'hF0;
      default: mk = 8'h00;
    endcase
  endfunction
  function [7:0] fix(input [4:0] a, input [7:0] v);
    fix = a[4] ? v & mk(a) : v | ~mk(a);
  endfunction
  function [7:0] rx(input [4:0] a);
    rx = (mk(a) == 8'h00 || a == 5'h08 || a == 5'h09) ? 8'h00 : m[a];
  endfunction
  task chk(input [127:0] seen, input [127:0] exp, input [63:0] what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task acc(input w, input q, input b, input [15:0] a, input [2:0] s, input [7:0] d);
    @(negedge clock_i);
    wr_i = w;
    rd_i = q;
    bit_i = b;
    addr_i = a;
    bit_sel_i = s;
    wdata_i = d;
    if (w && mk(a[4:0]) != 8'h00 && !(b && (a[4:0] == 5'h08 || a[4:0] == 5'h09)))
      m[a[4:0]] = fix(a[4:0], b ? (m[a[4:0]] & ~(8'h01 << s)) | (d & (8'h01 << s)) : d);
    @(posedge clock_i);
    #1;
    if (q) chk(rdata_o, rx(a[4:0]), "rdata");
  endtask
  task outs;
    @(negedge clock_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    chk({dir0_o, dir2_o, dir3_o, dir4_o, dir5_o, dir6_o, dir7_o, dir8_o, dir9_o, dir12_o},
      {m[0][5:0], m[2][5:0], m[3][4:0], m[4], m[5], m[6], m[7][3:0], m[8], m[9], m[12][0]}, "dir");
    chk({pu0_o, pu2_o, pu3_o, pu4_o, pu5_o, pu6_o, pu7_o, resistor_select_port12_o},
      {m[16][5:0], m[18][5:0], m[19][4:0], m[20], m[21], m[22][7:4], m[23][3:0], m[28][0]}, "pullup");
  endtask
  task do_reset;
    @(negedge clock_i);
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    for (j = 0; j < 32; j = j + 1) m[j] = j[4] ? 8'h00 : 8'hFF;
    repeat (3) @(negedge clock_i);
    rst_i = 1'b0;
  endtask
  task irq(input out);
    @(negedge clock_i);
    pulses = 0;
    others = 0;
    t0 = tog;
    @(posedge clock_i) en <= 1'b1;
    repeat (40) @(posedge clock_i);
    en <= 1'b0;
    repeat (8) @(negedge clock_i);
    chk(pulses, out ? tog - t0 : 16'h0000, "irq0");
    chk(others, 0, "irq1to5");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  // ==========
  // Main sequence
  initial begin
    {rst_i, wr_i, rd_i, bit_i, en, addr_i, bit_sel_i, wdata_i} = {5'h10, 16'hFF20, 3'h0, 8'h00};
    {mismatches, check_count, pulses, others} = 0;
    r = $urandom(32'h7C22);
    do_reset;
    outs;
    irq(1'b0);
    acc(1, 0, 0, 16'hFF28, 0, 8'h00);
    acc(1, 0, 1, 16'hFF28, 3, 8'hFF);
    acc(1, 0, 1, 16'hFF20, 0, 8'h00);
    acc(1, 0, 1, 16'hFF34, 7, 8'h80);
    acc(1, 0, 0, 16'hFF27, 0, 8'h00);
    acc(1, 0, 0, 16'hFF24, 0, 8'h5A);
    acc(1, 0, 0, 16'hFF21, 0, 8'h00);
    outs;
    irq(1'b1);
    for (j = 0; j < 200; j = j + 1) begin
      r = $urandom;
      acc(r[0], ~r[0] & r[1], r[2], 16'hFF20 + r[7:3], r[10:8], r[18:11]);
    end
    outs;
    do_reset;
    outs;
    for (r = 0; r < 32; r = r + 1) acc(0, 1, 0, 16'hFF20 + r[4:0], 0, 8'h00);
    end_of_test;
  end
endmodule // pdpc_port_ctrl_bench
